// ### ifw_irq_flags.sv
// Interrupt status, peripheral flags, wake-up enables and the two preset counters.
`timescale 1ns/1ps
module ifw_irq_flags #(
	parameter logic [7:0] PRESCALE_TOP = ifw_pkg::IFW_PRESCALE_TOP
) (
	// Clock and reset.
	input  wire logic                    clock,
	input  wire logic                    sys_rst,
	// Register port from the processor core.
	input  wire ifw_pkg::ifw_reg_req_type reg_req,
	output logic                   [7:0] reg_rdata_q,
	output logic                         reg_rvalid_q,
	// Peripheral events on the system clock.
	input  wire ifw_pkg::ifw_events_type  events,
	input  wire logic                    ext_irq_zero_edge_select,
	// External pins, asynchronous.
	input  wire logic              [3:0] port7_pins,
	input  wire logic              [3:0] port8_pins,
	// Results.
	output logic                   [7:0] interrupt_status_q,
	output logic                   [7:0] peripheral_flags_wake_enables_q,
	output logic                         wake_request_q
);
	import ifw_pkg::*;

	logic [7:0] pin_sync1_q;
	logic [7:0] pin_sync2_q;
	logic [7:0] pin_prev_q;
	logic [7:0] pin_fall;
	logic [7:0] pin_rise;
	logic       buf_full_prev_q;
	logic       buf_full_rise;
	logic       ext0_hit;
	logic [7:0] status_set;
	logic [7:0] flagwk_set;
	logic [7:0] status_keep;
	logic [7:0] flagwk_keep;
	logic       wr_status;
	logic       wr_flagwk;
	logic       wr_cnt_one;
	logic       wr_cnt_two;
	logic [7:0] cnt_one_q;
	logic [7:0] cnt_two_q;
	logic       cnt_one_ovf_q;
	logic       cnt_two_ovf_q;
	logic [3:0] wake_enables;

	// Two flops on every pin before any edge logic looks at it.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pin_sync1_q <= 8'hff;
			pin_sync2_q <= 8'hff;
		end else begin
			pin_sync1_q <= {port8_pins, port7_pins};
			pin_sync2_q <= pin_sync1_q;
		end
	end

	// Previous sample starts high, like the synchronisers, so a pin held high at reset gives no false rise.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pin_prev_q <= 8'hff;
			buf_full_prev_q <= 1'b0;
		end else begin
			pin_prev_q <= pin_sync2_q;
			buf_full_prev_q <= events.serial_buf_full;
		end
	end

	assign pin_fall = pin_prev_q & ~pin_sync2_q;
	assign pin_rise = ~pin_prev_q & pin_sync2_q;
	assign buf_full_rise = events.serial_buf_full & ~buf_full_prev_q;
	assign ext0_hit = ext_irq_zero_edge_select ? pin_fall[0] : pin_rise[0];

	// Register write decode.
	always_comb begin
		wr_status  = 1'b0;
		wr_flagwk  = 1'b0;
		wr_cnt_one = 1'b0;
		wr_cnt_two = 1'b0;
		if (reg_req.wr && reg_req.addr == IFW_ADDR_STATUS) begin
			wr_status = 1'b1;
		end else if (reg_req.wr && reg_req.addr == IFW_ADDR_FLAGS_WK && reg_req.page == IFW_PAGE_FLAGS_WK) begin
			wr_flagwk = 1'b1;
		end else if (reg_req.wr && reg_req.addr == IFW_ADDR_CNT_ONE && reg_req.page == IFW_PAGE_CNT) begin
			wr_cnt_one = 1'b1;
		end else if (reg_req.wr && reg_req.addr == IFW_ADDR_CNT_TWO && reg_req.page == IFW_PAGE_CNT) begin
			wr_cnt_two = 1'b1;
		end
	end

	// Hardware set terms.
	always_comb begin
		status_set                 = 8'h00;
		status_set[IFW_ST_TIMER]   = events.timer_ovf;
		status_set[IFW_ST_CNT_ONE] = cnt_one_ovf_q;
		status_set[IFW_ST_CNT_TWO] = cnt_two_ovf_q;
		status_set[IFW_ST_EXT0]    = ext0_hit;
		status_set[IFW_ST_EXT1]    = pin_fall[1];
		status_set[IFW_ST_EXT2]    = pin_fall[2];
		status_set[IFW_ST_EXT3]    = pin_fall[3];
		flagwk_set                 = 8'h00;
		flagwk_set[IFW_FW_PWM_A]   = events.pwm_a_period;
		flagwk_set[IFW_FW_ADC]     = events.adc_done;
		flagwk_set[IFW_FW_SERIAL]  = buf_full_rise;
		flagwk_set[IFW_FW_PWM_B]   = events.pwm_b_period;
	end

	// A write of zero clears a flag, a write of one leaves it; software cannot forge an event.
	assign status_keep = wr_status ? (interrupt_status_q & reg_req.wdata) : interrupt_status_q;
	assign flagwk_keep = wr_flagwk ? (peripheral_flags_wake_enables_q & reg_req.wdata) : peripheral_flags_wake_enables_q;

	// Set wins over a clear in the same cycle so no event is dropped.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			interrupt_status_q <= IFW_RST_STATUS;
		end else begin
			interrupt_status_q <= (status_keep | status_set) & ~(8'h01 << IFW_ST_UNUSED);
		end
	end

	// Enable nibble is plain read/write; flag nibble follows the status rules.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			peripheral_flags_wake_enables_q <= IFW_RST_FLAGS_WK;
		end else begin
			peripheral_flags_wake_enables_q[IFW_FW_PWM_B:IFW_FW_PWM_A] <=
				flagwk_keep[IFW_FW_PWM_B:IFW_FW_PWM_A] | flagwk_set[IFW_FW_PWM_B:IFW_FW_PWM_A];
			if (wr_flagwk) begin
				peripheral_flags_wake_enables_q[IFW_FW_WAKE_HI:IFW_FW_WAKE_LO] <=
					reg_req.wdata[IFW_FW_WAKE_HI:IFW_FW_WAKE_LO];
			end
		end
	end

	assign wake_enables = peripheral_flags_wake_enables_q[IFW_FW_WAKE_HI:IFW_FW_WAKE_LO];

	// Wake request is a one-cycle pulse per enabled falling edge on port 8.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wake_request_q <= 1'b0;
		end else begin
			wake_request_q <= |(pin_fall[7:4] & wake_enables);
		end
	end

	ifw_counter #(
		.PRESCALE_TOP (PRESCALE_TOP)
	) u_counter_one (
		.clock      (clock),
		.sys_rst    (sys_rst),
		.load       (wr_cnt_one),
		.load_value (reg_req.wdata),
		.count_q    (cnt_one_q),
		.overflow_q (cnt_one_ovf_q)
	);

	ifw_counter #(
		.PRESCALE_TOP (PRESCALE_TOP)
	) u_counter_two (
		.clock      (clock),
		.sys_rst    (sys_rst),
		.load       (wr_cnt_two),
		.load_value (reg_req.wdata),
		.count_q    (cnt_two_q),
		.overflow_q (cnt_two_ovf_q)
	);

	// Read data is registered; an unmapped address reads as zero.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			reg_rdata_q  <= IFW_RD_IDLE;
			reg_rvalid_q <= 1'b0;
		end else begin
			reg_rvalid_q <= reg_req.rd;
			if (!reg_req.rd) begin
				reg_rdata_q <= IFW_RD_IDLE;
			end else if (reg_req.addr == IFW_ADDR_STATUS) begin
				reg_rdata_q <= interrupt_status_q;
			end else if (reg_req.addr == IFW_ADDR_FLAGS_WK && reg_req.page == IFW_PAGE_FLAGS_WK) begin
				reg_rdata_q <= peripheral_flags_wake_enables_q;
			end else if (reg_req.addr == IFW_ADDR_CNT_ONE && reg_req.page == IFW_PAGE_CNT) begin
				reg_rdata_q <= cnt_one_q;
			end else if (reg_req.addr == IFW_ADDR_CNT_TWO && reg_req.page == IFW_PAGE_CNT) begin
				reg_rdata_q <= cnt_two_q;
			end else begin
				reg_rdata_q <= IFW_RD_IDLE;
			end
		end
	end

	// Named sequences for multi-step pin behaviour.
	sequence s_pin71_fall;
		pin_sync2_q[1] ##1 !pin_sync2_q[1];
	endsequence

	sequence s_pin70_rise_sel;
		(!pin_sync2_q[0] && !ext_irq_zero_edge_select) ##1 (pin_sync2_q[0] && !ext_irq_zero_edge_select);
	endsequence

	sequence s_pin70_fall_sel;
		(pin_sync2_q[0] && ext_irq_zero_edge_select) ##1 (!pin_sync2_q[0] && ext_irq_zero_edge_select);
	endsequence

	sequence s_wake80_fall;
		pin_sync2_q[4] ##1 (!pin_sync2_q[4] && wake_enables[0]);
	endsequence

	chk_timer_flag_set: assert property (@(posedge clock) disable iff (sys_rst)
		events.timer_ovf |=> interrupt_status_q[IFW_ST_TIMER])
		else $error("timer event did not set status bit 0");

	chk_cnt_one_flag: assert property (@(posedge clock) disable iff (sys_rst)
		cnt_one_ovf_q |=> interrupt_status_q[IFW_ST_CNT_ONE])
		else $error("counter one overflow did not set status bit 1");

	chk_cnt_two_flag: assert property (@(posedge clock) disable iff (sys_rst)
		cnt_two_ovf_q |=> interrupt_status_q[IFW_ST_CNT_TWO])
		else $error("counter two overflow did not set status bit 2");

	chk_ext0_rise: assert property (@(posedge clock) disable iff (sys_rst)
		s_pin70_rise_sel |=> interrupt_status_q[IFW_ST_EXT0])
		else $error("rising edge on pin 70 did not set flag");

	chk_ext0_fall: assert property (@(posedge clock) disable iff (sys_rst)
		s_pin70_fall_sel |=> interrupt_status_q[IFW_ST_EXT0])
		else $error("falling edge on pin 70 did not set flag");

	chk_ext1_fall: assert property (@(posedge clock) disable iff (sys_rst)
		s_pin71_fall |=> interrupt_status_q[IFW_ST_EXT1])
		else $error("falling edge on pin 71 did not set flag");

	chk_ext2_fall: assert property (@(posedge clock) disable iff (sys_rst)
		pin_fall[2] |=> interrupt_status_q[IFW_ST_EXT2])
		else $error("falling edge on pin 72 did not set flag");

	chk_ext3_unused: assert property (@(posedge clock) disable iff (sys_rst)
		(pin_fall[3] |=> interrupt_status_q[IFW_ST_EXT3]) and (##1 !interrupt_status_q[IFW_ST_UNUSED]))
		else $error("pin 73 flag missing or unused bit set");

	chk_status_hold: assert property (@(posedge clock) disable iff (sys_rst)
		(!wr_status && interrupt_status_q != 8'h00) |=> ((interrupt_status_q & $past(interrupt_status_q))
			== $past(interrupt_status_q)))
		else $error("status flag dropped without a write");

	chk_status_clear: assert property (@(posedge clock) disable iff (sys_rst)
		(wr_status && reg_req.wdata == 8'h00 && status_set == 8'h00) |=> interrupt_status_q == 8'h00)
		else $error("writing zero did not clear status");

	chk_wake_pulse: assert property (@(posedge clock) disable iff (sys_rst)
		s_wake80_fall |=> wake_request_q)
		else $error("enabled falling edge on pin 80 did not wake");

	chk_wake_gated: assert property (@(posedge clock) disable iff (sys_rst)
		(pin_fall[7:4] & wake_enables) == 4'h0 |=> !wake_request_q)
		else $error("wake request without enabled falling edge");

	chk_pwm_a_flag: assert property (@(posedge clock) disable iff (sys_rst)
		events.pwm_a_period |=> peripheral_flags_wake_enables_q[IFW_FW_PWM_A])
		else $error("pwm a period did not set flag");

	chk_pwm_b_flag: assert property (@(posedge clock) disable iff (sys_rst)
		events.pwm_b_period |=> peripheral_flags_wake_enables_q[IFW_FW_PWM_B])
		else $error("pwm b period did not set flag");

	chk_adc_flag: assert property (@(posedge clock) disable iff (sys_rst)
		events.adc_done |=> peripheral_flags_wake_enables_q[IFW_FW_ADC])
		else $error("adc done did not set flag");

	chk_serial_rise: assert property (@(posedge clock) disable iff (sys_rst)
		(!events.serial_buf_full ##1 events.serial_buf_full) |=> peripheral_flags_wake_enables_q[IFW_FW_SERIAL])
		else $error("serial buffer-full rise did not set flag");

	chk_cnt_one_read: assert property (@(posedge clock) disable iff (sys_rst)
		(reg_req.rd && reg_req.addr == IFW_ADDR_CNT_ONE && reg_req.page == IFW_PAGE_CNT)
			|=> (reg_rvalid_q && reg_rdata_q == $past(cnt_one_q)))
		else $error("counter one read returned wrong value");

	chk_cnt_two_load: assert property (@(posedge clock) disable iff (sys_rst)
		wr_cnt_two |=> cnt_two_q == $past(reg_req.wdata))
		else $error("counter two write did not preset count");

	chk_edge_once: assert property (@(posedge clock) disable iff (sys_rst)
		(pin_sync2_q[1] == pin_prev_q[1]) |-> !status_set[IFW_ST_EXT1])
		else $error("pin 71 flag set without a transition");

endmodule

// ### ifw_pkg.sv
// Package with register map, field positions and carrier types of the flag and counter block.
package ifw_pkg;

	localparam int unsigned IFW_DATA_W = 8;
	localparam int unsigned IFW_ADDR_W = 6;
	localparam int unsigned IFW_PAGE_W = 2;

	// Register addresses and the pages of the counters and flag register; status decodes on any page.
	localparam logic [5:0] IFW_ADDR_CNT_ONE  = 6'h0c;
	localparam logic [5:0] IFW_ADDR_CNT_TWO  = 6'h0d;
	localparam logic [5:0] IFW_ADDR_FLAGS_WK = 6'h0e;
	localparam logic [5:0] IFW_ADDR_STATUS   = 6'h0f;
	localparam logic [1:0] IFW_PAGE_CNT      = 2'h1;
	localparam logic [1:0] IFW_PAGE_FLAGS_WK = 2'h0;

	// Reset values.
	localparam logic [7:0] IFW_RST_STATUS   = 8'h00;
	localparam logic [7:0] IFW_RST_FLAGS_WK = 8'h00;
	localparam logic [7:0] IFW_RST_COUNT    = 8'h00;
	localparam logic [7:0] IFW_RD_IDLE      = 8'h00;

	// Interrupt status field positions.
	localparam int unsigned IFW_ST_TIMER = 0;
	localparam int unsigned IFW_ST_CNT_ONE = 1;
	localparam int unsigned IFW_ST_CNT_TWO = 2;
	localparam int unsigned IFW_ST_EXT0  = 3;
	localparam int unsigned IFW_ST_EXT1  = 4;
	localparam int unsigned IFW_ST_EXT2  = 5;
	localparam int unsigned IFW_ST_UNUSED = 6;
	localparam int unsigned IFW_ST_EXT3  = 7;

	// Flag and wake-up register field positions.
	localparam int unsigned IFW_FW_WAKE_LO = 0;
	localparam int unsigned IFW_FW_WAKE_HI = 3;
	localparam int unsigned IFW_FW_PWM_A   = 4;
	localparam int unsigned IFW_FW_ADC     = 5;
	localparam int unsigned IFW_FW_SERIAL  = 6;
	localparam int unsigned IFW_FW_PWM_B   = 7;

	// Prescaler terminal value and counter top.
	localparam logic [7:0] IFW_PRESCALE_TOP = 8'hff;
	localparam logic [7:0] IFW_COUNT_TOP    = 8'hff;

	typedef struct packed {
		logic [5:0] addr;
		logic [1:0] page;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} ifw_reg_req_type;

	typedef struct packed {
		logic timer_ovf;
		logic pwm_a_period;
		logic pwm_b_period;
		logic adc_done;
		logic serial_buf_full;
	} ifw_events_type;

endpackage

// ### ifw_counter.sv
// Eight-bit preset/reload up-counter with an eight-bit prescaler.
`timescale 1ns/1ps
module ifw_counter #(
	parameter logic [7:0] PRESCALE_TOP = ifw_pkg::IFW_PRESCALE_TOP
) (
	// Clock and reset.
	input  wire logic       clock,
	input  wire logic       sys_rst,
	// Preset load from the register port.
	input  wire logic       load,
	input  wire logic [7:0] load_value,
	// Count and overflow.
	output logic      [7:0] count_q,
	output logic            overflow_q
);
	import ifw_pkg::*;

	logic [7:0] prescale_q;
	logic [7:0] preset_q;
	logic       tick;

	assign tick = (prescale_q == PRESCALE_TOP);

	always_ff @(posedge clock) begin
		if (sys_rst || load) begin
			prescale_q <= IFW_RST_COUNT;
		end else if (tick) begin
			prescale_q <= IFW_RST_COUNT;
		end else begin
			prescale_q <= prescale_q + 8'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			preset_q <= IFW_RST_COUNT;
		end else if (load) begin
			preset_q <= load_value;
		end
	end

	// A write takes priority over a pending roll so the new preset is never lost.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			count_q    <= IFW_RST_COUNT;
			overflow_q <= 1'b0;
		end else if (load) begin
			count_q    <= load_value;
			overflow_q <= 1'b0;
		end else if (tick && count_q == IFW_COUNT_TOP) begin
			count_q    <= preset_q;
			overflow_q <= 1'b1;
		end else begin
			count_q    <= tick ? count_q + 8'h01 : count_q;
			overflow_q <= 1'b0;
		end
	end

	chk_reload_preset: assert property (@(posedge clock) disable iff (sys_rst)
		(tick && count_q == IFW_COUNT_TOP && !load) |=> (overflow_q && count_q == $past(preset_q)))
		else $error("counter did not reload preset on overflow");

endmodule

// ### ifw_core_model.sv
// Processor core model that reads, writes and clears the flag and counter registers.
`timescale 1ns/1ps
module ifw_core_model (
	// Clock.
	input  wire logic                clock,
	// Register port towards the flag block.
	output ifw_pkg::ifw_reg_req_type reg_req,
	input  wire logic          [7:0] reg_rdata_q,
	input  wire logic                reg_rvalid_q
);
	import ifw_pkg::*;

	initial reg_req = '0;

	// A slow core leaves idle cycles before an access; the block must answer the same.
	task automatic reg_write(input logic [5:0] addr, input logic [1:0] page, input logic [7:0] data, input int idle);
		repeat (idle + 1) @(posedge clock);
		#1;
		reg_req = '{addr: addr, page: page, wr: 1'b1, rd: 1'b0, wdata: data};
		@(posedge clock);
		#1;
		reg_req.wr = 1'b0;
	endtask

	// Read data stands for one cycle only, so it is taken right after the answering edge.
	task automatic reg_read(input logic [5:0] addr, input logic [1:0] page, input int idle,
		output logic [7:0] data, output logic valid);
		repeat (idle + 1) @(posedge clock);
		#1;
		reg_req = '{addr: addr, page: page, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge clock);
		#1;
		reg_req.rd = 1'b0;
		data = reg_rdata_q;
		valid = reg_rvalid_q;
	endtask
endmodule

// ### ifw_irq_flags_tb.sv
// Self-checking testbench of the flag, wake-up and counter block.
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin err_total++; $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp); end end
module ifw_irq_flags_tb;
	import ifw_pkg::*;

	logic                 clock = 1'b0;
	logic                 sys_rst = 1'b1;
	ifw_reg_req_type      reg_req;
	logic           [7:0] reg_rdata_q;
	logic                 reg_rvalid_q;
	logic           [4:0] ev_bits = 5'h00;
	logic                 ext_irq_zero_edge_select = 1'b0;
	logic           [3:0] port7_pins = 4'hf;
	logic           [3:0] port8_pins = 4'hf;
	logic           [7:0] interrupt_status_q;
	logic           [7:0] peripheral_flags_wake_enables_q;
	logic                 wake_request_q;
	int                   err_total = 0;
	int                   comparisons = 0;

	// Event bit order follows the carrier: serial, adc, pwm b, pwm a, timer.
	localparam logic [7:0] EV_MASK [5] = '{8'h40, 8'h20, 8'h80, 8'h10, 8'h01};
	localparam logic [7:0] PIN_MASK [4] = '{8'h08, 8'h10, 8'h20, 8'h80};

	always #2 clock = ~clock;

	ifw_irq_flags #(
		.PRESCALE_TOP (8'hff)
	) u_ifw_irq_flags (
		.clock                           (clock),
		.sys_rst                         (sys_rst),
		.reg_req                         (reg_req),
		.reg_rdata_q                     (reg_rdata_q),
		.reg_rvalid_q                    (reg_rvalid_q),
		.events                          (ifw_events_type'(ev_bits)),
		.ext_irq_zero_edge_select        (ext_irq_zero_edge_select),
		.port7_pins                      (port7_pins),
		.port8_pins                      (port8_pins),
		.interrupt_status_q              (interrupt_status_q),
		.peripheral_flags_wake_enables_q (peripheral_flags_wake_enables_q),
		.wake_request_q                  (wake_request_q)
	);

	ifw_core_model u_ifw_core_model (
		.clock        (clock),
		.reg_req      (reg_req),
		.reg_rdata_q  (reg_rdata_q),
		.reg_rvalid_q (reg_rvalid_q)
	);

	task automatic rd_chk(input logic [5:0] a, input logic [1:0] p, input logic [7:0] exp, input string msg);
		logic [7:0] d;
		logic       v;
		u_ifw_core_model.reg_read(a, p, 0, d, v);
		`CHK(v, 1'b1, "read valid")
		`CHK(d, exp, msg)
	endtask

	task automatic wr(input logic [5:0] a, input logic [1:0] p, input logic [7:0] data);
		u_ifw_core_model.reg_write(a, p, data, 0);
	endtask

	task automatic pulse(input int b);
		@(posedge clock);
		#1;
		ev_bits[b] = 1'b1;
		@(posedge clock);
		#1;
		ev_bits[b] = 1'b0;
	endtask

	// Pins pass two synchroniser stages, so five cycles covers the flag latency.
	task automatic set_pin(input int i, input logic v);
		@(posedge clock);
		#1;
		port7_pins[i] = v;
		repeat (5) @(posedge clock);
	endtask

	task automatic wake_cnt(input int i, input logic v, output int n);
		@(posedge clock);
		#1;
		port8_pins[i] = v;
		n = 0;
		repeat (6) begin
			@(posedge clock);
			#1;
			if (wake_request_q !== 1'b0) n++;
		end
	endtask

	task automatic results;
		$display("Comparisons %0d, errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		results();
	end

	initial begin
		logic [7:0] d;
		logic       v;
		logic       ok;
		logic       done;
		int         n;
		repeat (8) @(posedge clock);
		#1;
		sys_rst = 1'b0;
		rd_chk(IFW_ADDR_STATUS, 2'h0, IFW_RST_STATUS, "status reset");
		rd_chk(IFW_ADDR_FLAGS_WK, IFW_PAGE_FLAGS_WK, IFW_RST_FLAGS_WK, "flags reset");
		rd_chk(IFW_ADDR_CNT_ONE, IFW_PAGE_CNT, 8'h00, "count one reset");
		rd_chk(IFW_ADDR_CNT_TWO, IFW_PAGE_CNT, 8'h00, "count two reset");
		for (int i = 0; i < 5; i++) begin
			d = (i == 4) ? IFW_ADDR_STATUS : IFW_ADDR_FLAGS_WK;
			pulse(i);
			repeat (3) @(posedge clock);
			rd_chk(d[5:0], 2'h0, EV_MASK[i], "event flag held");
			`CHK((i == 4) ? interrupt_status_q : peripheral_flags_wake_enables_q, EV_MASK[i], "flag port")
			wr(d[5:0], 2'h0, 8'h00);
			rd_chk(d[5:0], 2'h0, 8'h00, "event flag cleared");
		end
		// A buffer-full level held high must not set the flag again once cleared.
		@(posedge clock);
		#1;
		ev_bits[0] = 1'b1;
		rd_chk(IFW_ADDR_FLAGS_WK, 2'h0, 8'h40, "serial rise");
		wr(IFW_ADDR_FLAGS_WK, 2'h0, 8'h00);
		rd_chk(IFW_ADDR_FLAGS_WK, 2'h0, 8'h00, "serial level only");
		ev_bits[0] = 1'b0;
		wr(IFW_ADDR_STATUS, 2'h0, 8'hff);
		rd_chk(IFW_ADDR_STATUS, 2'h0, 8'h00, "write one never sets");
		for (int i = 1; i < 4; i++) begin
			set_pin(i, 1'b0);
			rd_chk(IFW_ADDR_STATUS, 2'h0, PIN_MASK[i], "pin fall");
			`CHK(interrupt_status_q, PIN_MASK[i], "status port")
			set_pin(i, 1'b1);
			rd_chk(IFW_ADDR_STATUS, 2'h0, PIN_MASK[i], "pin rise keeps");
			wr(IFW_ADDR_STATUS, 2'h0, 8'h00);
			rd_chk(IFW_ADDR_STATUS, 2'h0, 8'h00, "pin cleared");
		end
		set_pin(0, 1'b0);
		rd_chk(IFW_ADDR_STATUS, 2'h0, 8'h00, "pin zero fall ignored");
		set_pin(0, 1'b1);
		rd_chk(IFW_ADDR_STATUS, 2'h0, 8'h08, "pin zero rise");
		wr(IFW_ADDR_STATUS, 2'h0, 8'h00);
		ext_irq_zero_edge_select = 1'b1;
		set_pin(0, 1'b0);
		rd_chk(IFW_ADDR_STATUS, 2'h0, 8'h08, "pin zero fall");
		wr(IFW_ADDR_STATUS, 2'h0, 8'h00);
		set_pin(0, 1'b1);
		rd_chk(IFW_ADDR_STATUS, 2'h0, 8'h00, "pin zero rise ignored");
		wr(IFW_ADDR_FLAGS_WK, IFW_PAGE_FLAGS_WK, 8'h05);
		rd_chk(IFW_ADDR_FLAGS_WK, IFW_PAGE_FLAGS_WK, 8'h05, "wake enables");
		for (int i = 0; i < 4; i++) begin
			wake_cnt(i, 1'b0, n);
			`CHK(n, (i % 2 == 0) ? 1 : 0, "wake on fall")
			wake_cnt(i, 1'b1, n);
			`CHK(n, 0, "no wake on rise")
		end
		rd_chk(IFW_ADDR_CNT_ONE, 2'h0, 8'h00, "unmapped page read");
		wr(IFW_ADDR_FLAGS_WK, 2'h1, 8'hff);
		rd_chk(IFW_ADDR_FLAGS_WK, 2'h1, 8'h00, "unmapped read");
		rd_chk(IFW_ADDR_FLAGS_WK, IFW_PAGE_FLAGS_WK, 8'h05, "unmapped write ignored");
		wr(IFW_ADDR_CNT_ONE, IFW_PAGE_CNT, 8'hfe);
		wr(IFW_ADDR_CNT_TWO, IFW_PAGE_CNT, 8'hfd);
		wr(IFW_ADDR_STATUS, 2'h0, 8'h00);
		// Without a reload the counts would wrap to zero, which the range checks catch.
		done = 1'b0;
		for (int k = 0; k < 400 && !done; k++) begin
			u_ifw_core_model.reg_read(IFW_ADDR_CNT_ONE, IFW_PAGE_CNT, 0, d, v);
			ok = d inside {8'hfe, 8'hff};
			`CHK(ok, 1'b1, "count one range")
			u_ifw_core_model.reg_read(IFW_ADDR_CNT_TWO, IFW_PAGE_CNT, 0, d, v);
			ok = d inside {8'hfd, 8'hfe, 8'hff};
			`CHK(ok, 1'b1, "count two range")
			u_ifw_core_model.reg_read(IFW_ADDR_STATUS, 2'h0, 0, d, v);
			done = ((d & 8'h06) === 8'h06);
		end
		`CHK(done, 1'b1, "counter overflow flags")
		results();
	end
endmodule
